// >>> ascii_link_pkg.sv
// Shared constants, states and carriers of the ASCII link station
package ascii_link_pkg;

  // ==========================================================
  // Character codes
  localparam logic [7:0] SOH_C     = 8'h01;
  localparam logic [7:0] ETX_C     = 8'h03;
  localparam logic [7:0] ENQ_C     = 8'h05;
  localparam logic [7:0] ACK_C     = 8'h06;
  localparam logic [7:0] NAK_C     = 8'h15;
  localparam logic [7:0] ZERO_C    = 8'h30;
  localparam logic [7:0] ALPHA_OFS = 8'h37;
  localparam logic [7:0] CMD_R     = 8'h52;
  localparam logic [7:0] CMD_W     = 8'h57;
  localparam logic [7:0] CMD_A     = 8'h41;
  localparam logic [7:0] CMD_E     = 8'h45;
  localparam logic [7:0] CMD_LA    = 8'h61;
  localparam logic [7:0] CMD_LE    = 8'h65;
  localparam logic [7:0] CMD_LF    = 8'h66;
  localparam logic [7:0] CMD_LG    = 8'h67;
  localparam logic [7:0] CMD_LH    = 8'h68;
  localparam logic [7:0] CMD_LJ    = 8'h6A;
  localparam logic [7:0] CMD_LK    = 8'h6B;
  localparam logic [7:0] CMD_LM    = 8'h6D;
  localparam logic [7:0] GRP_S     = 8'h53;
  localparam logic [7:0] GRP_H     = 8'h48;
  localparam logic [15:0] NUM_08   = 16'h3038;
  localparam logic [15:0] NUM_09   = 16'h3039;
  localparam logic [15:0] NUM_03   = 16'h3033;
  localparam logic [6:0] STN_BCAST = 7'h63;
  localparam logic [6:0] TEN       = 7'h0A;

  // ==========================================================
  // Frame layout
  localparam logic [4:0] LEN_STD   = 5'h10;
  localparam logic [4:0] LEN_OPT_L = 5'h0C;
  localparam logic [4:0] LEN_OPT_S = 5'h08;
  localparam logic [4:0] IX_ST_HI  = 5'h01;
  localparam logic [4:0] IX_ST_LO  = 5'h02;
  localparam logic [4:0] IX_CTL    = 5'h03;
  localparam logic [4:0] IX_CMD    = 5'h04;
  localparam logic [4:0] IX_GRP    = 5'h05;
  localparam logic [4:0] IX_NUM    = 5'h06;
  localparam logic [4:0] IX_ODAT   = 5'h05;
  localparam logic [4:0] IX_SDAT   = 5'h09;
  localparam logic [4:0] IX_OETX   = 5'h09;

  // ==========================================================
  // Error codes and selector values
  localparam logic [7:0] ERR_CHECKSUM = 8'h47;
  localparam logic [7:0] ERR_FORMAT   = 8'h4A;
  localparam logic [7:0] ERR_COMMAND  = 8'h4B;
  localparam logic [7:0] ERR_BUSY     = 8'h51;
  localparam logic [15:0] SEL_INIT    = 16'h0001;
  localparam logic [15:0] SEL_MOTOR   = 16'h0002;

  // ==========================================================
  // Timing in ms and clock rate
  localparam int CLK_KHZ     = 40000;
  localparam int T2_FAST_MS  = 10;
  localparam int T2_SLOW_MS  = 100;
  localparam int T2_MOTOR_MS = 500;
  localparam int T2_INIT_MS  = 5000;
  localparam int TMR_W       = 28;
  localparam int IVL_W       = 10;

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_EXEC, S_DELAY, S_CSUM, S_SEND
  } phase_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  grp;
    logic [15:0] num;
    logic [15:0] data;
    logic        bcast;
  } exec_req_t;

  typedef struct packed {
    logic        done;
    logic [7:0]  err;
    logic [15:0] rdata;
  } exec_rsp_t;

endpackage

// >>> ascii_hex_digit.sv
// One nibble to one upper-case hexadecimal ASCII character
`timescale 1ns/1ps
module ascii_hex_digit
  import ascii_link_pkg::*;
(
  input  wire logic [3:0] nib_i,  // Binary nibble
  output logic      [7:0] asc_o   // ASCII digit 0-9, A-F
);
  // Letters stay upper case so the far end can compare bytes
  assign asc_o = (nib_i < 4'hA) ? ZERO_C + {4'h0, nib_i}
                                : ALPHA_OFS + {4'h0, nib_i};
endmodule

// >>> ascii_link_station.sv
// Station-side transaction engine of the ASCII framed half-duplex link
// Behaviour
// - Valid standard write is acked, echoing fields, ACK replacing ENQ, new checksum
// - Standard read answers four upper-case hex digits of the value
// - Optional operation write acked by short frame: station, ACK, command, ETX, sum
// - Rejected optional write gets short NAK frame and stores error code
// - Station 99 is broadcast: execute, never reply
// - Frames use 7-bit ASCII controls, digits, upper-case letters and lower-case optional command letters
// - Response time is settable interval delay plus transaction time
// - Reads, fast writes, resets, specific codes, most S writes finish in 10 ms
// - Motor init 500 ms, data init 5 s, other writes 100 ms
// - Checksum is low byte of sum of all bytes but header and checksum
// - Device is ready to receive within 5 ms after responding
`timescale 1ns/1ps
module ascii_link_station
  import ascii_link_pkg::*;
#(
  parameter logic [TMR_W-1:0] FAST_CYC  = TMR_W'(T2_FAST_MS * CLK_KHZ),
  parameter logic [TMR_W-1:0] SLOW_CYC  = TMR_W'(T2_SLOW_MS * CLK_KHZ),
  parameter logic [TMR_W-1:0] MOTOR_CYC = TMR_W'(T2_MOTOR_MS * CLK_KHZ),
  parameter logic [TMR_W-1:0] INIT_CYC  = TMR_W'(T2_INIT_MS * CLK_KHZ),
  parameter logic [15:0]      MS_CYC    = 16'(CLK_KHZ)
)(
  input  wire logic             clk_i,          // System clock
  input  wire logic             rstn_i,         // Async reset, low
  input  wire logic [6:0]       station_i,      // Own station number
  input  wire logic [IVL_W-1:0] response_interval_setting_i, // Delay in ms
  input  wire logic             rx_valid_i,     // Received byte strobe
  input  wire logic [7:0]       rx_data_i,      // Received byte
  input  wire logic             tx_ready_i,     // Transmitter takes byte
  output logic                  tx_valid_o,     // Byte to send
  output logic      [7:0]       tx_data_o,      // Byte value
  output logic                  exec_req_o,     // Execute pulse
  output exec_req_t             exec_o,         // Decoded request
  input  wire exec_rsp_t        exec_rsp_i,     // Execution result
  output logic      [7:0]       last_comm_error_code_o, // Latest error
  output logic                  busy_o          // Not receiving
);

  typedef struct packed {
    phase_t             ph;
    logic [4:0]         idx;
    logic [4:0]         len;
    logic [15:0][7:0]   fr;
    logic [TMR_W-1:0]   tmr;
    logic [TMR_W-1:0]   lim;
    logic [15:0]        pre;
    logic [IVL_W-1:0]   ms;
    logic               nak;
    logic               req;
    exec_req_t          ex;
    logic [7:0]         err;
    logic               txv;
    logic [7:0]         txd;
    logic               busy;
  } core_t;

  core_t q, n;
  logic [7:0]      sum;
  logic [5:0][7:0] asc;
  logic [6:0]      stn;
  logic [7:0]      cmd;
  logic [7:0]      ecode;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] dec(input logic [7:0] c);
    return (c >= 8'h41) ? 4'(c - ALPHA_OFS) : 4'(c - ZERO_C);
  endfunction

  function automatic logic is_sel(input logic [7:0] c);
    return c == CMD_LA || c == CMD_LE || c == CMD_LF || c == CMD_LM;
  endfunction

  function automatic logic is_poll(input logic [7:0] c);
    return c == CMD_LG || c == CMD_LH || c == CMD_LJ || c == CMD_LK;
  endfunction

  function automatic logic known(input logic [7:0] c);
    return is_sel(c) || is_poll(c) || c == CMD_R || c == CMD_W
        || c == CMD_A || c == CMD_E;
  endfunction

  // Unknown commands are framed as standard so the NAK has a shape
  function automatic logic [4:0] req_len(input logic [7:0] c);
    return is_sel(c) ? LEN_OPT_L : (is_poll(c) ? LEN_OPT_S : LEN_STD);
  endfunction

  function automatic logic [4:0] rsp_len(input logic [7:0] c);
    return is_sel(c) ? LEN_OPT_S : (is_poll(c) ? LEN_OPT_L : LEN_STD);
  endfunction

  // Rewrites the received frame in place into the answer
  function automatic logic [15:0][7:0] shape(input logic [15:0][7:0] f,
      input logic nk, input logic [31:0] d);
    logic [7:0] c;
    c = f[IX_CMD];
    f[IX_CTL] = nk ? NAK_C : ACK_C;
    if (is_sel(c)) begin
      f[IX_ODAT] = ETX_C;
    end else if (is_poll(c)) begin
      for (int k = 0; k < 4; k++) f[IX_ODAT + 5'(k)] = d[31 - 8*k -: 8];
      f[IX_OETX] = ETX_C;
    end else if (c == CMD_R && !nk) begin
      for (int k = 0; k < 4; k++) f[IX_SDAT + 5'(k)] = d[31 - 8*k -: 8];
    end
    return f;
  endfunction

  // ==========================================================
  // Checksum over bytes 1..len-3 and hex digits of sum and read data
  always_comb begin
    sum = 8'h00;
    for (int i = 1; i < 16; i++) begin
      if (5'(i) <= q.len - 5'h03) sum = sum + q.fr[i];
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_hex
    logic [23:0] nibs;
    assign nibs = {sum, exec_rsp_i.rdata};
    ascii_hex_digit u_dig (
      .nib_i (nibs[4*g +: 4]),
      .asc_o (asc[g])
    );
  end

  assign cmd   = q.fr[IX_CMD];
  assign stn   = {3'h0, dec(q.fr[IX_ST_HI])} * TEN + {3'h0, dec(q.fr[IX_ST_LO])};
  assign ecode = exec_rsp_i.done ? exec_rsp_i.err : ERR_BUSY;

  // ==========================================================
  // Next state
  always_comb begin
    logic [4:0]  db;
    logic [15:0] dv;
    logic [7:0]  fe;
    n     = q;
    n.req = 1'b0;
    db    = is_sel(cmd) ? IX_ODAT : IX_SDAT;
    dv    = {dec(q.fr[db]), dec(q.fr[db + 5'h01]),
             dec(q.fr[db + 5'h02]), dec(q.fr[db + 5'h03])};
    fe    = 8'h00;
    case (q.ph)
      // Collect bytes; a header always restarts the frame
      S_IDLE: begin
        if (rx_valid_i) begin
          if (rx_data_i == SOH_C) begin
            n.fr[0] = rx_data_i;
            n.idx   = IX_ST_HI;
            n.len   = LEN_STD;
          end else if (q.idx != 5'h00) begin
            n.fr[q.idx] = rx_data_i;
            n.idx       = q.idx + 5'h01;
            if (q.idx == IX_CMD) n.len = req_len(rx_data_i);
            if (q.idx + 5'h01 == q.len) begin
              n.ph  = S_CHECK;
              n.idx = 5'h00;
            end
          end
        end
      end
      S_CHECK: begin
        n.ex = '{cmd: cmd, grp: q.fr[IX_GRP],
                 num: {q.fr[IX_NUM], q.fr[IX_NUM + 5'h01]},
                 data: dv, bcast: stn == STN_BCAST};
        if (stn != station_i && stn != STN_BCAST) begin
          n.ph = S_IDLE;
        end else if ({asc[5], asc[4]} !=
                     {q.fr[q.len - 5'h02], q.fr[q.len - 5'h01]}) begin
          n.err = ERR_CHECKSUM;
          n.ph  = S_IDLE;
        end else begin
          if (q.fr[IX_CTL] != ENQ_C || q.fr[q.len - 5'h03] != ETX_C) begin
            fe = ERR_FORMAT;
          end else if (!known(cmd)) begin
            fe = ERR_COMMAND;
          end
          if (fe != 8'h00) begin
            n.err = fe;
            n.nak = 1'b1;
            n.fr  = shape(q.fr, 1'b1, {4{ZERO_C}});
            n.len = rsp_len(cmd);
            n.ph  = n.ex.bcast ? S_IDLE : S_DELAY;
          end else begin
            n.req = 1'b1;
            n.nak = 1'b0;
            n.ph  = S_EXEC;
            n.tmr = '0;
            n.lim = FAST_CYC;
            if (cmd == CMD_W) begin
              if (n.ex.grp == GRP_S && n.ex.num != NUM_08 && n.ex.num != NUM_09) begin
                n.lim = FAST_CYC;
              end else if (n.ex.grp == GRP_H && n.ex.num == NUM_03 && dv == SEL_INIT) begin
                n.lim = INIT_CYC;
              end else if (n.ex.grp == GRP_H && n.ex.num == NUM_03 && dv == SEL_MOTOR) begin
                n.lim = MOTOR_CYC;
              end else begin
                n.lim = SLOW_CYC;
              end
            end
          end
        end
        n.pre = 16'h0000;
        n.ms  = '0;
      end
      // Execution is cut off at the bound so the host timeout holds
      S_EXEC: begin
        n.tmr = q.tmr + 1'b1;
        if (exec_rsp_i.done || q.tmr >= q.lim) begin
          n.nak = ecode != 8'h00;
          if (n.nak) n.err = ecode;
          n.fr  = shape(q.fr, n.nak, {asc[3], asc[2], asc[1], asc[0]});
          n.len = rsp_len(cmd);
          n.ph  = q.ex.bcast ? S_IDLE : S_DELAY;
        end
      end
      S_DELAY: begin
        if (q.ms >= response_interval_setting_i) begin
          n.ph = S_CSUM;
        end else if (q.pre == MS_CYC - 16'h0001) begin
          n.pre = 16'h0000;
          n.ms  = q.ms + 1'b1;
        end else begin
          n.pre = q.pre + 16'h0001;
        end
      end
      S_CSUM: begin
        n.fr[q.len - 5'h02] = asc[5];
        n.fr[q.len - 5'h01] = asc[4];
        n.idx = 5'h00;
        n.ph  = S_SEND;
      end
      // Back to receive right after the last byte
      S_SEND: begin
        if (!q.txv || tx_ready_i) begin
          if (q.idx < q.len) begin
            n.txv = 1'b1;
            n.txd = q.fr[q.idx];
            n.idx = q.idx + 5'h01;
          end else begin
            n.txv = 1'b0;
            n.idx = 5'h00;
            n.ph  = S_IDLE;
          end
        end
      end
      default: n.ph = S_IDLE;
    endcase
    n.busy = n.ph != S_IDLE;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tx_valid_o             = q.txv;
  assign tx_data_o              = q.txd;
  assign exec_req_o             = q.req;
  assign exec_o                 = q.ex;
  assign last_comm_error_code_o = q.err;
  assign busy_o                 = q.busy;

  // ==========================================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_ack_ctl;
    q.ph == S_CSUM && !q.nak |-> q.fr[IX_CTL] == ACK_C && q.fr[IX_CMD] == cmd;
  endproperty
  a_ack_ctl: assert property (p_ack_ctl) else $error("ack control wrong");

  property p_read_digits;
    q.ph == S_EXEC && exec_rsp_i.done && exec_rsp_i.err == 8'h00 && cmd == CMD_R
      |=> q.fr[IX_SDAT + 5'h03] == $past(asc[0]) && q.fr[IX_SDAT] == $past(asc[3]);
  endproperty
  a_read_digits: assert property (p_read_digits) else $error("read digits");

  property p_short_ack;
    q.ph == S_CSUM && is_sel(cmd) |-> q.len == LEN_OPT_S && q.fr[IX_ODAT] == ETX_C;
  endproperty
  a_short_ack: assert property (p_short_ack) else $error("short frame");

  property p_err_kept;
    q.ph == S_EXEC && exec_rsp_i.done && exec_rsp_i.err != 8'h00
      |=> q.err == $past(exec_rsp_i.err) && q.fr[IX_CTL] == NAK_C;
  endproperty
  a_err_kept: assert property (p_err_kept) else $error("error not kept");

  // In CHECK the stored request still belongs to the previous frame, so look at the frame
  property p_bcast_quiet;
    (q.ph == S_EXEC && q.ex.bcast) || (q.ph == S_CHECK && stn == STN_BCAST)
      |=> q.ph != S_DELAY;
  endproperty
  a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast reply");

  property p_interval;
    q.ph == S_DELAY && q.ms < response_interval_setting_i |=> q.ph == S_DELAY;
  endproperty
  a_interval: assert property (p_interval) else $error("reply too early");

  property p_bound;
    q.ph == S_EXEC |-> q.tmr <= q.lim ##1 q.ph == S_EXEC || q.tmr <= q.lim + 1'b1;
  endproperty
  a_bound: assert property (p_bound) else $error("transaction overrun");

  property p_init_lim;
    q.ph == S_EXEC && cmd == CMD_W && q.ex.grp == GRP_H && q.ex.num == NUM_03
      && q.ex.data == SEL_INIT |-> q.lim == INIT_CYC;
  endproperty
  a_init_lim: assert property (p_init_lim) else $error("init bound");

  property p_csum;
    q.ph == S_CSUM |=> q.fr[q.len - 5'h02] == asc[5] && q.fr[q.len - 5'h01] == asc[4];
  endproperty
  a_csum: assert property (p_csum) else $error("checksum digits");

  property p_ready;
    q.ph == S_SEND && q.idx == q.len && tx_ready_i |=> q.ph == S_IDLE && !q.txv;
  endproperty
  a_ready: assert property (p_ready) else $error("not back to receive");

  property p_foreign;
    q.ph == S_CHECK && stn != station_i && stn != STN_BCAST |=> q.ph == S_IDLE;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign frame taken");

  c_bcast: cover property (q.ph == S_EXEC && q.ex.bcast ##1 q.ph == S_IDLE);
  c_nak:   cover property (q.ph == S_CSUM && q.nak);
  c_read:  cover property (q.ph == S_CSUM && cmd == CMD_R && !q.nak);
  c_short: cover property (q.ph == S_CSUM && is_sel(cmd) && !q.nak);

endmodule

// >>> ascii_host_model.sv
// Host controller model that sends request frames and collects replies
`timescale 1ns/1ps
module ascii_host_model (
  input  wire logic       clk_i,       // System clock
  input  wire logic       busy_i,      // Station not receiving
  input  wire logic       tx_valid_i,  // Reply byte offered
  input  wire logic [7:0] tx_data_i,   // Reply byte
  output logic            rx_valid_o,  // Request byte strobe
  output logic      [7:0] rx_data_o,   // Request byte
  output logic            tx_ready_o   // Reply byte taken
);
  // ==========================================================
  // Host side state
  bit slow;  // Stall two cycles before each reply byte

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
    slow       = 1'b0;
  end

  // ==========================================================
  // Request byte, held back until the station listens and a gap has passed
  task automatic put(input logic [7:0] b);
    int n;
    for (n = 0; n < 400 && busy_i !== 1'b0; n++) @(negedge clk_i);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o  = {1'b0, b[6:0]};
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o  = ~b;  // Stale data must not look valid
  endtask

  // ==========================================================
  // Reply byte; the wait bound exceeds any response time of the station
  task automatic take(input int lim, output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b  = 8'h00;
    for (n = 0; n < lim && !ok; n++) begin
      @(negedge clk_i);
      tx_ready_o = !slow || (n >= 2);
      @(posedge clk_i);
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
        b  = tx_data_i;
        ok = 1'b1;
      end
    end
    @(negedge clk_i);
    tx_ready_o = 1'b0;
  endtask
endmodule

// >>> inverter_ascii_link_transactions_tb_top.sv
// Self-checking testbench of the ASCII link station
`timescale 1ns/1ps
module inverter_ascii_link_transactions_tb_top;
  import ascii_link_pkg::*;
  typedef logic [7:0] bq_t[$];

  // ==========================================================
  // Signals and bench state
  logic             clk_i, rstn_i, tx_valid, exec_req, busy, rxv;
  logic [7:0]       tx_data, last_err, rxd;
  logic             txr;
  logic [IVL_W-1:0] ivl;
  exec_req_t        eo;
  exec_rsp_t        rsp;
  bq_t              frm, got;
  int               bad_count, cmp_count, cyc, t_req, t_done, t_first, n_req, dly;
  bit               pend, hang;
  logic [7:0]       rsp_err;
  logic [15:0]      rsp_dat;
  logic [6:0]       stn_id;

  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    ivl = '0;
    rsp = '0;
    rsp_err = 8'h00;
    rsp_dat = 16'h0000;
    stn_id = 7'h0C;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    n_req = 0;
    dly = 0;
    pend = 0;
    hang = 0;
  end
  always #12.5 clk_i = ~clk_i;

  ascii_link_station #(
    .FAST_CYC(28'd20), .SLOW_CYC(28'd40), .MOTOR_CYC(28'd60), .INIT_CYC(28'd80),
    .MS_CYC(16'd4)
  ) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .station_i(stn_id), .response_interval_setting_i(ivl),
    .rx_valid_i(rxv), .rx_data_i(rxd), .tx_ready_i(txr), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .exec_req_o(exec_req), .exec_o(eo), .exec_rsp_i(rsp),
    .last_comm_error_code_o(last_err), .busy_o(busy)
  );

  ascii_host_model host (
    .clk_i(clk_i), .busy_i(busy), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .rx_valid_o(rxv), .rx_data_o(rxd), .tx_ready_o(txr)
  );

  // ==========================================================
  // Executor stand-in: answers after dly cycles, or never while hang is set
  // Done is written once per step so the pulse never collides with its own clear
  always @(negedge clk_i) begin
    if (exec_req === 1'b1) begin
      rsp.done <= 1'b0;
      pend <= 1'b1;
      t_req <= cyc;
      n_req <= n_req + 1;
    end else if (pend && !hang && cyc - t_req >= dly) begin
      rsp <= '{1'b1, rsp_err, rsp_dat};
      pend <= 1'b0;
      t_done <= cyc;
    end else begin
      rsp.done <= 1'b0;
    end
  end

  // Cycle count and hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // Frame from its text, checksum of all bytes after the header appended
  task automatic mk(input string s);
    logic [7:0] sum;
    frm = {};
    sum = 8'h00;
    for (int i = 0; i < s.len(); i++) begin
      frm.push_back(s[i]);
      if (i > 0) sum += s[i];
    end
    frm.push_back(hx(sum[7:4]));
    frm.push_back(hx(sum[3:0]));
  endtask

  task automatic send_s(input string s, input bit bad_sum);
    mk(s);
    if (bad_sum) frm[frm.size() - 1] = frm[frm.size() - 1] ^ 8'h01;
    foreach (frm[i]) host.put(frm[i]);
  endtask

  task automatic recv(input int n);
    logic [7:0] b;
    bit         ok;
    got = {};
    for (int i = 0; i < n; i++) begin
      host.take(200, b, ok);
      if (!ok) break;
      if (i == 0) t_first = cyc;
      got.push_back(b);
    end
  endtask

  task automatic cmp_frame(input string s);
    mk(s);
    chkv("reply_length", 16'(frm.size()), 16'(got.size()));
    foreach (frm[i]) if (i < got.size()) chkv("reply_byte", 16'(frm[i]), 16'(got[i]));
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_write();
    ivl = 10'd3;
    host.slow = 1'b1;
    dly = 5;
    send_s("\00112\005WS01 0FA0\003", 0);
    recv(16);
    cmp_frame("\00112\006WS01 0FA0\003");
    chkv("exec_cmd", 16'(CMD_W), 16'(eo.cmd));
    chkv("exec_grp", 16'(GRP_S), 16'(eo.grp));
    chkv("exec_num", 16'h3031, eo.num);
    chkv("exec_data", 16'h0FA0, eo.data);
    chkb("reply_delay", 1'b1, (t_first - t_done >= 12) && (t_first - t_done <= 20));
    repeat (2) @(negedge clk_i);
    chkb("busy_after_reply", 1'b0, busy);
    ivl = 10'd0;
    host.slow = 1'b0;
    dly = 0;
  endtask

  task automatic s_read();
    rsp_dat = 16'h0BB8;
    send_s("\00112\005RM09 0000\003", 0);
    recv(16);
    cmp_frame("\00112\006RM09 0BB8\003");
  endtask

  task automatic s_opt_ack();
    send_s("\00112\005f0001\003", 0);
    recv(12);
    cmp_frame("\00112\006f\003");
  endtask

  task automatic s_opt_nak();
    rsp_err = 8'h4F;
    send_s("\00112\005f0001\003", 0);
    recv(12);
    cmp_frame("\00112\025f\003");
    chkv("last_error", 16'h004F, 16'(last_err));
    rsp_err = 8'h00;
  endtask

  // Unknown command, wrong end mark byte (STX in place of ETX), then a short polling read
  task automatic s_reject();
    int n0;
    n0 = n_req;
    send_s("\00112\005ZS01 0000\003", 0);
    recv(16);
    cmp_frame("\00112\025ZS01 0000\003");
    chkv("command_error", 16'(ERR_COMMAND), 16'(last_err));
    send_s("\00112\005f0001\002", 0);
    recv(8);
    cmp_frame("\00112\025f\003");
    chkv("format_error", 16'(ERR_FORMAT), 16'(last_err));
    chkv("reject_exec_count", 16'(n0), 16'(n_req));
    rsp_dat = 16'h1A0B;
    send_s("\00112\005j\003", 0);
    recv(12);
    cmp_frame("\00112\006j1A0B\003");
  endtask

  task automatic s_bcast();
    int n0;
    n0 = n_req;
    send_s("\00199\005f0002\003", 0);
    recv(1);
    chkv("bcast_reply_length", 16'h0000, 16'(got.size()));
    chkv("bcast_exec_count", 16'(n0 + 1), 16'(n_req));
    chkb("bcast_flag", 1'b1, eo.bcast);
  endtask

  task automatic s_ignored();
    int n0;
    n0 = n_req;
    send_s("\00105\005f0001\003", 0);
    recv(1);
    chkv("other_reply_length", 16'h0000, 16'(got.size()));
    send_s("\00112\005f0001\003", 1);
    recv(1);
    chkv("badsum_reply_length", 16'h0000, 16'(got.size()));
    chkv("badsum_error", 16'h0047, 16'(last_err));
    chkv("ignored_exec_count", 16'(n0), 16'(n_req));
    // After the silent timeout the host resends the same frame intact
    send_s("\00112\005f0001\003", 0);
    recv(8);
    cmp_frame("\00112\006f\003");
    // A new own number makes the former foreign station the addressee
    stn_id = 7'h05;
    send_s("\00105\005f0001\003", 0);
    recv(8);
    cmp_frame("\00105\006f\003");
    stn_id = 7'h0C;
  endtask

  task automatic s_overrun();
    string req [4];
    int    lim [4];
    req = '{"\00112\005WS01 0000\003", "\00112\005WS08 0000\003",
            "\00112\005WH03 0001\003", "\00112\005WH03 0002\003"};
    lim = '{20, 40, 80, 60};
    hang = 1'b1;
    foreach (req[i]) begin
      send_s(req[i], 0);
      recv(16);
      chkv("overrun_length", 16'h0010, 16'(got.size()));
      if (got.size() > 3) chkv("overrun_ctl", 16'(NAK_C), 16'(got[3]));
      chkb("overrun_time", 1'b1, (t_first - t_req >= lim[i]) && (t_first - t_req <= lim[i] + 10));
      chkv("overrun_error", 16'(ERR_BUSY), 16'(last_err));
    end
    hang = 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    @(negedge clk_i);
    s_write();
    s_read();
    s_opt_ack();
    s_opt_nak();
    s_reject();
    s_bcast();
    s_ignored();
    s_overrun();
    finish_test();
  end
endmodule
